/* hdl/i2c_clr_pkg.sv */
// Constants, types and decode helper for the interrupt read-clear block
// Overview of operation
// - Reading overflow-clear register clears bit 3
// - Reading read-request-clear register clears bit 5
// - Abort-clear read clears bit 6, abort record
// - Abort-clear read releases flushed transmit FIFO
// - Abort record bit 9 keeps own clearing
// - Reading receive-done-clear register clears bit 7
// - Activity clears on read only when idle
// - Activity self-clears when disabled and idle
// - Activity-clear read returns bit 8 value
// - Clear registers 16 bits, bit 0 only
package i2c_clr_pkg;

  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned NUM_FLAGS = 6;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] reg16_t;

  // Flag indices inside the flag vector
  localparam int unsigned IDX_TX_OVER  = 0;
  localparam int unsigned IDX_RD_REQ   = 1;
  localparam int unsigned IDX_TRANSMIT_ABORT_FLAG  = 2;
  localparam int unsigned IDX_RX_DONE  = 3;
  localparam int unsigned IDX_ACTIVITY = 4;
  localparam int unsigned IDX_STOP_DETECT_FLAG = 5;

  // Byte addresses of the read-clear registers
  localparam addr_t TX_OVERFLOW_FLAG_CLEAR_ADDR  = 32'h5000134C;
  localparam addr_t READ_REQUEST_FLAG_CLEAR_ADDR = 32'h50001350;
  localparam addr_t TX_ABORT_FLAG_CLEAR_ADDR     = 32'h50001354;
  localparam addr_t RECEIVE_DONE_FLAG_CLEAR_ADDR = 32'h50001358;
  localparam addr_t BUS_ACTIVITY_FLAG_CLEAR_ADDR = 32'h5000135C;
  localparam addr_t STOP_DETECT_FLAG_CLEAR_ADDR  = 32'h50001360;
  // Flag view and interrupt mask
  localparam addr_t RAW_STATUS_ADDR              = 32'h500013F0;
  localparam addr_t IRQ_MASK_ADDR                = 32'h500013F4;

  localparam addr_t CLR_ADDR [NUM_FLAGS] = '{
    TX_OVERFLOW_FLAG_CLEAR_ADDR,
    READ_REQUEST_FLAG_CLEAR_ADDR,
    TX_ABORT_FLAG_CLEAR_ADDR,
    RECEIVE_DONE_FLAG_CLEAR_ADDR,
    BUS_ACTIVITY_FLAG_CLEAR_ADDR,
    STOP_DETECT_FLAG_CLEAR_ADDR
  };

  // Flag positions in the raw interrupt status word
  localparam int unsigned TX_OVER_BIT  = 3;
  localparam int unsigned RD_REQ_BIT   = 5;
  localparam int unsigned TRANSMIT_ABORT_FLAG_BIT  = 6;
  localparam int unsigned RX_DONE_BIT  = 7;
  localparam int unsigned ACTIVITY_BIT = 8;
  localparam int unsigned STOP_DETECT_FLAG_BIT = 9;

  localparam int unsigned FLAG_POS [NUM_FLAGS] = '{
    TX_OVER_BIT, RD_REQ_BIT, TRANSMIT_ABORT_FLAG_BIT,
    RX_DONE_BIT, ACTIVITY_BIT, STOP_DETECT_FLAG_BIT
  };

  // Functional bit of every clear register
  localparam int unsigned CLR_BIT = 0;
  // Abort record bit with its own clearing condition
  localparam int unsigned ABRT_KEEP_BIT = 9;

  localparam reg16_t CLR_REG_RESET    = 16'h0000;
  localparam reg16_t RAW_STATUS_RESET = 16'h0000;
  localparam reg16_t IRQ_MASK_RESET   = 16'h0000;
  localparam reg16_t ABRT_SRC_RESET   = 16'h0000;
  localparam reg16_t RDATA_RESET      = 16'h0000;
  localparam logic   FLAG_RESET       = 1'b0;

  typedef enum logic {
    TXF_OPEN    = 1'b0,
    TXF_FLUSHED = 1'b1
  } txf_state_t;

  function automatic logic addr_hit(input addr_t a, input addr_t r);
    return a == r;
  endfunction

endpackage // i2c_clr_pkg

/* hdl/clr_access_if.sv */
// Decoded register accesses passed from decoder to core
`timescale 1ns/100ps
interface clr_access_if;
  import i2c_clr_pkg::*;

  logic [NUM_FLAGS-1:0] clr_rd_hit;
  logic                 raw_rd_hit;
  logic                 raw_wr_hit;
  logic                 mask_rd_hit;
  logic                 mask_wr_hit;

  modport dec (
    output clr_rd_hit,
    output raw_rd_hit,
    output raw_wr_hit,
    output mask_rd_hit,
    output mask_wr_hit
  );

  modport core (
    input clr_rd_hit,
    input raw_rd_hit,
    input raw_wr_hit,
    input mask_rd_hit,
    input mask_wr_hit
  );
endinterface // clr_access_if

/* hdl/clr_decode.sv */
// Address decoder for the read-clear register group
`timescale 1ns/100ps
module clr_decode (
  input  wire i2c_clr_pkg::addr_t bus_addr, // Byte address
  input  wire logic               bus_wr,   // Write strobe
  input  wire logic               bus_rd,   // Read strobe
  clr_access_if.dec               acc       // Decoded hits
);
  import i2c_clr_pkg::*;

  // Clear registers react to reads only
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_clr
      assign acc.clr_rd_hit[g] = bus_rd && addr_hit(bus_addr, CLR_ADDR[g]);
    end
  endgenerate

  assign acc.raw_rd_hit  = bus_rd && addr_hit(bus_addr, RAW_STATUS_ADDR);
  assign acc.raw_wr_hit  = bus_wr && addr_hit(bus_addr, RAW_STATUS_ADDR);
  assign acc.mask_rd_hit = bus_rd && addr_hit(bus_addr, IRQ_MASK_ADDR);
  assign acc.mask_wr_hit = bus_wr && addr_hit(bus_addr, IRQ_MASK_ADDR);

endmodule // clr_decode

/* hdl/i2c_irq_clear.sv */
// Read-to-clear interrupt flags, abort record and FIFO release logic
`timescale 1ns/100ps
module i2c_irq_clear (
  input  wire logic                core_clk,         // Clock, 50 MHz
  input  wire logic                reset,            // Async reset, high
  input  wire i2c_clr_pkg::addr_t  bus_addr,         // Register address
  input  wire i2c_clr_pkg::reg16_t bus_wdata,        // Write data
  input  wire logic                bus_wr,           // Write strobe
  input  wire logic                bus_rd,           // Read strobe
  output      i2c_clr_pkg::reg16_t bus_rdata,        // Read data, next cycle
  input  wire logic                tx_over_evt,      // Transmit overflow
  input  wire logic                rd_req_evt,       // Read request
  input  wire logic                transmit_abort_flag_evt,      // Transmit abort
  input  wire i2c_clr_pkg::reg16_t abort_cause,      // Abort causes
  input  wire logic                rx_done_evt,      // Receive done
  input  wire logic                activity_evt,     // Bus activity seen
  input  wire logic                stop_detect_flag_evt,     // Stop detected
  input  wire logic                ctrl_enable,      // Controller enabled
  input  wire logic                bus_active,       // Controller busy
  input  wire logic                abort_keep_clear, // Clears record bit 9
  output      i2c_clr_pkg::reg16_t raw_interrupt_status, // Flag word
  output      i2c_clr_pkg::reg16_t abort_source_record,  // Abort record
  output logic                     tx_fifo_flushed,  // FIFO held flushed
  output logic                     irq               // Level interrupt
);
  import i2c_clr_pkg::*;

  clr_access_if acc ();

  clr_decode u_decode (
    .bus_addr (bus_addr),
    .bus_wr   (bus_wr),
    .bus_rd   (bus_rd),
    .acc      (acc.dec)
  );

  logic [NUM_FLAGS-1:0] flag_ff;
  logic [NUM_FLAGS-1:0] nxt_flag;
  logic [NUM_FLAGS-1:0] evt_vec;
  logic [NUM_FLAGS-1:0] rd_clr;
  logic [NUM_FLAGS-1:0] w1c_clr;
  logic [NUM_FLAGS-1:0] clr_ok;
  logic [NUM_FLAGS-1:0] hw_clr;
  reg16_t               raw_word;
  reg16_t               flag_mask;
  reg16_t               mask_ff;
  reg16_t               abrt_src_ff;
  reg16_t               nxt_abrt_src;
  reg16_t               rdata_ff;
  reg16_t               rd_val;
  txf_state_t           txf_ff;
  txf_state_t           nxt_txf;
  logic                 idle;
  logic                 abrt_clr_rd;

  // Event vector in flag-index order
  always_comb begin
    evt_vec               = '0;
    evt_vec[IDX_TX_OVER]  = tx_over_evt;
    evt_vec[IDX_RD_REQ]   = rd_req_evt;
    evt_vec[IDX_TRANSMIT_ABORT_FLAG]  = transmit_abort_flag_evt;
    evt_vec[IDX_RX_DONE]  = rx_done_evt;
    evt_vec[IDX_ACTIVITY] = activity_evt;
    evt_vec[IDX_STOP_DETECT_FLAG] = stop_detect_flag_evt;
  end

  assign idle        = !bus_active;
  assign abrt_clr_rd = acc.clr_rd_hit[IDX_TRANSMIT_ABORT_FLAG];

  // Which clears are allowed right now
  always_comb begin
    clr_ok               = '1;
    hw_clr               = '0;
    clr_ok[IDX_ACTIVITY] = idle;
    hw_clr[IDX_ACTIVITY] = !ctrl_enable && idle;
  end

  // Software clear sources
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      assign rd_clr[g]  = acc.clr_rd_hit[g] && clr_ok[g];
      assign w1c_clr[g] = acc.raw_wr_hit && bus_wdata[FLAG_POS[g]]
                          && clr_ok[g];
      // Set wins over any clear
      assign nxt_flag[g] = evt_vec[g] ||
                           (flag_ff[g] && !(rd_clr[g] || w1c_clr[g] ||
                                            hw_clr[g]));

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          flag_ff[g] <= FLAG_RESET;
        end else begin
          flag_ff[g] <= nxt_flag[g];
        end
      end
    end
  endgenerate

  // Flag word and its implemented-bit mask
  always_comb begin
    raw_word  = RAW_STATUS_RESET;
    flag_mask = '0;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      raw_word[FLAG_POS[i]]  = flag_ff[i];
      flag_mask[FLAG_POS[i]] = 1'b1;
    end
  end

  assign raw_interrupt_status = raw_word;

  // Abort record update
  always_comb begin
    nxt_abrt_src = abrt_src_ff;
    if (abrt_clr_rd) begin
      nxt_abrt_src = abrt_src_ff & (16'h0001 << ABRT_KEEP_BIT);
    end
    if (abort_keep_clear) begin
      nxt_abrt_src[ABRT_KEEP_BIT] = 1'b0;
    end
    if (transmit_abort_flag_evt) begin
      nxt_abrt_src = nxt_abrt_src | abort_cause;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      abrt_src_ff <= ABRT_SRC_RESET;
    end else begin
      abrt_src_ff <= nxt_abrt_src;
    end
  end

  assign abort_source_record = abrt_src_ff;

  // Transmit FIFO hold after an abort
  always_comb begin
    case (txf_ff)
      TXF_OPEN: begin
        nxt_txf = transmit_abort_flag_evt ? TXF_FLUSHED : TXF_OPEN;
      end
      TXF_FLUSHED: begin
        nxt_txf = (abrt_clr_rd && !transmit_abort_flag_evt) ? TXF_OPEN : TXF_FLUSHED;
      end
      default: begin
        nxt_txf = TXF_OPEN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      txf_ff <= TXF_OPEN;
    end else begin
      txf_ff <= nxt_txf;
    end
  end

  assign tx_fifo_flushed = (txf_ff == TXF_FLUSHED);

  // Interrupt mask register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask_ff <= IRQ_MASK_RESET;
    end else if (acc.mask_wr_hit) begin
      mask_ff <= bus_wdata & flag_mask;
    end
  end

  assign irq = |(raw_word & mask_ff);

  // Read data selection
  always_comb begin
    rd_val = CLR_REG_RESET;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      if (acc.clr_rd_hit[i]) begin
        rd_val[CLR_BIT] = flag_ff[i];
      end
    end
    if (acc.raw_rd_hit) begin
      rd_val = raw_word;
    end
    if (acc.mask_rd_hit) begin
      rd_val = mask_ff;
    end
  end

  // Read data stand one cycle only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= RDATA_RESET;
    end else if (bus_rd) begin
      rdata_ff <= rd_val;
    end else begin
      rdata_ff <= RDATA_RESET;
    end
  end

  assign bus_rdata = rdata_ff;

endmodule // i2c_irq_clear

/* tb/i2c_irq_clear_sva.sv */
// Port assertions for the read-clear interrupt block
`timescale 1ns/100ps
module i2c_irq_clear_sva (
  input wire logic                core_clk,             // Clock
  input wire logic                reset,                // Async reset
  input wire i2c_clr_pkg::addr_t  bus_addr,             // Address
  input wire logic                bus_wr,               // Write strobe
  input wire logic                bus_rd,               // Read strobe
  input wire i2c_clr_pkg::reg16_t bus_rdata,            // Read data
  input wire logic                tx_over_evt,          // Overflow event
  input wire logic                rd_req_evt,           // Request event
  input wire logic                transmit_abort_flag_evt,          // Abort event
  input wire logic                rx_done_evt,          // Done event
  input wire logic                activity_evt,         // Activity event
  input wire logic                ctrl_enable,          // Enable
  input wire logic                bus_active,           // Busy
  input wire logic                abort_keep_clear,     // Bit 9 clear
  input wire i2c_clr_pkg::reg16_t raw_interrupt_status, // Flags
  input wire i2c_clr_pkg::reg16_t abort_source_record,  // Record
  input wire logic                tx_fifo_flushed       // FIFO flushed
);
  import i2c_clr_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic   in_clr;
  reg16_t raw;
  assign raw = raw_interrupt_status;
  assign in_clr = bus_addr inside {[TX_OVERFLOW_FLAG_CLEAR_ADDR:
                                    STOP_DETECT_FLAG_CLEAR_ADDR]};
  ovf_clear_a: assert property (bus_rd && !tx_over_evt &&
    bus_addr == TX_OVERFLOW_FLAG_CLEAR_ADDR
    |=> !raw[3] && bus_rdata[0] == $past(raw[3]))
    else $error("overflow flag not cleared by read");
  req_clear_a: assert property (bus_rd && !rd_req_evt &&
    bus_addr == READ_REQUEST_FLAG_CLEAR_ADDR |=> !raw[5])
    else $error("read request flag not cleared");
  abort_clear_a: assert property (bus_rd && !transmit_abort_flag_evt &&
    bus_addr == TX_ABORT_FLAG_CLEAR_ADDR |=> !raw[6] && !tx_fifo_flushed)
    else $error("abort flag or fifo flush not released");
  record_keep_a: assert property (bus_rd && !transmit_abort_flag_evt &&
    !abort_keep_clear && bus_addr == TX_ABORT_FLAG_CLEAR_ADDR
    |=> (abort_source_record & 16'hFDFF) == 16'h0000 &&
    $stable(abort_source_record[9]))
    else $error("abort record clear wrong");
  done_clear_a: assert property (bus_rd && !rx_done_evt &&
    bus_addr == RECEIVE_DONE_FLAG_CLEAR_ADDR |=> !raw[7])
    else $error("receive done flag not cleared");
  busy_hold_a: assert property (bus_rd && bus_active && raw[8] &&
    bus_addr == BUS_ACTIVITY_FLAG_CLEAR_ADDR |=> raw[8])
    else $error("activity cleared while busy");
  auto_idle_a: assert property (!ctrl_enable && !bus_active &&
    !activity_evt |=> !raw[8])
    else $error("activity not cleared when disabled");
  act_read_a: assert property (bus_rd &&
    bus_addr == BUS_ACTIVITY_FLAG_CLEAR_ADDR
    |=> bus_rdata == {15'h0000, $past(raw[8])})
    else $error("activity read value wrong");
  reserved_zero_a: assert property (bus_rd && in_clr
    |=> bus_rdata[15:1] == 15'h0000)
    else $error("reserved bits not zero");
  write_none_a: assert property (bus_wr && in_clr
    |=> (raw & $past(raw) & 16'h00E8) == ($past(raw) & 16'h00E8))
    else $error("write to clear register changed a flag");
endmodule // i2c_irq_clear_sva
bind i2c_irq_clear i2c_irq_clear_sva chk (.*);

/* tb/testbench.sv */
// Self-checking bench for the read-clear interrupt block
`timescale 1ns/100ps
module testbench;
  import i2c_clr_pkg::*;
  logic       core_clk = 1'b0, reset = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic       ctrl_enable = 1'b1, bus_active = 1'b0, keep_clr = 1'b0;
  logic [5:0] evt = 6'h00;
  addr_t      bus_addr = 32'h00000000;
  reg16_t     bus_wdata = 16'h0000, abort_cause = 16'h0000;
  reg16_t     bus_rdata, raw, rec, d;
  logic       flushed, irq;
  int         bad_count = 0, checked = 0, cycles = 0;
  i2c_irq_clear DUT (
    .core_clk(core_clk), .reset(reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .tx_over_evt(evt[0]), .rd_req_evt(evt[1]),
    .transmit_abort_flag_evt(evt[2]), .abort_cause(abort_cause), .rx_done_evt(evt[3]),
    .activity_evt(evt[4]), .stop_detect_flag_evt(evt[5]),
    .ctrl_enable(ctrl_enable), .bus_active(bus_active),
    .abort_keep_clear(keep_clr), .raw_interrupt_status(raw),
    .abort_source_record(rec), .tx_fifo_flushed(flushed), .irq(irq));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input string n, input reg16_t s, input reg16_t e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rd(input addr_t a, output reg16_t v);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    v = bus_rdata;
  endtask
  task automatic wr(input addr_t a, input reg16_t v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge core_clk);
    evt[i] <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    check("raw", raw, 16'h0000);
    check("record", rec, 16'h0000);
    check("flushed", flushed, 16'h0000);
    for (int i = 0; i < NUM_FLAGS; i++) begin
      rd(CLR_ADDR[i], d);
      check("clear reg reset", d, 16'h0000);
    end
  endtask
  task automatic t_flags;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      pulse(i);
      check("flag set", raw, 16'h0001 << FLAG_POS[i]);
      wr(CLR_ADDR[i], 16'hFFFF);
      check("after write", raw, 16'h0001 << FLAG_POS[i]);
      rd(CLR_ADDR[i], d);
      check("clear read", d, 16'h0001);
      check("flag cleared", raw, 16'h0000);
    end
  endtask
  task automatic t_abort;
    abort_cause <= 16'h0281;
    pulse(IDX_TRANSMIT_ABORT_FLAG);
    abort_cause <= 16'h0000;
    check("record", rec, 16'h0281);
    check("flushed", flushed, 16'h0001);
    rd(TX_ABORT_FLAG_CLEAR_ADDR, d);
    check("record kept", rec, 16'h0200);
    check("released", flushed, 16'h0000);
    check("abort flag", raw, 16'h0000);
    keep_clr <= 1'b1;
    @(posedge core_clk);
    keep_clr <= 1'b0;
    #1;
    check("record bit 9", rec, 16'h0000);
  endtask
  task automatic t_activity;
    pulse(IDX_ACTIVITY);
    bus_active <= 1'b1;
    rd(BUS_ACTIVITY_FLAG_CLEAR_ADDR, d);
    check("activity read", d, 16'h0001);
    check("activity busy", raw, 16'h0100);
    bus_active <= 1'b0;
    ctrl_enable <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    #1;
    check("activity auto", raw, 16'h0000);
    ctrl_enable <= 1'b1;
    rd(BUS_ACTIVITY_FLAG_CLEAR_ADDR, d);
    check("activity idle read", d, 16'h0000);
  endtask
  task automatic t_irq;
    wr(IRQ_MASK_ADDR, 16'hFFFF);
    rd(IRQ_MASK_ADDR, d);
    check("mask", d, 16'h03E8);
    pulse(IDX_TX_OVER);
    check("irq", irq, 16'h0001);
    wr(IRQ_MASK_ADDR, 16'h0000);
    check("irq masked", irq, 16'h0000);
    wr(IRQ_MASK_ADDR, 16'h0008);
    check("irq unmasked", irq, 16'h0001);
    wr(RAW_STATUS_ADDR, 16'h0008);
    check("irq cleared", irq, 16'h0000);
    rd(32'h50001400, d);
    check("unmapped", d, 16'h0000);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset;
    t_flags;
    t_abort;
    t_activity;
    t_irq;
    stop_test;
  end
endmodule // testbench
